/* File: cfg_cmd_regs.sv */
// Purpose: output configuration command registers and the settings they steer
// Assumes: straps are static pins; vout/iout inputs come from pclk logic
// Notes:   vout words are 2^-13 V lsb; iout in signed mA
`timescale 1ns/100ps
module cfg_cmd_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  cfg_cmd_if.device        link,
  input  wire logic [15:0] strap_freq_word,
  input  wire logic [6:0]  strap_address,
  input  wire logic [15:0] strap_vout_word,
  input  wire logic        output_enable,
  input  wire logic        output_ramping,
  input  wire logic [1:0]  margin_select,
  input  wire logic [15:0] vout_nominal,
  input  wire logic [15:0] vout_margin_high,
  input  wire logic [15:0] vout_margin_low,
  input  wire logic [15:0] iout_ma,
  input  wire logic        share_group,
  input  wire logic [3:0]  auto_position,
  output logic      [15:0] vout_setpoint,
  output logic      [6:0]  freq_divisor,
  output logic      [4:0]  phase_position_eff,
  output logic      [6:0]  phase_delay_ticks,
  output logic      [15:0] ov_threshold
);
  // ****************************************
  // strap synchronisers and load
  // ****************************************
  logic [38:0] strap_s1_q;
  logic [38:0] strap_s2_q;
  logic [1:0]  load_cnt_q;
  logic        loaded_q;
  logic        strap_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end else begin
      strap_s1_q <= {strap_freq_word, strap_address, strap_vout_word};
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_q <= '0;
      loaded_q   <= 1'b0;
    end else if (!loaded_q) begin
      load_cnt_q <= load_cnt_q + 2'h1;
      loaded_q   <= (load_cnt_q == cfg_cmd_pkg::STRAP_LOAD_CNT);
    end
  end
  assign strap_load = !loaded_q && (load_cnt_q == cfg_cmd_pkg::STRAP_LOAD_CNT);

  // ****************************************
  // command handling
  // ****************************************
  logic [15:0] slew_q;
  logic [15:0] droop_q;
  logic [15:0] freq_q;
  logic [15:0] pos_q;
  logic [15:0] ov_q;
  logic        ack_q;
  logic        unsup_q;
  logic [15:0] rdata_q;
  logic        on_q;
  logic        take;
  logic        wr;
  logic [27:0] ov_prod;

  assign take    = link.req && !ack_q && loaded_q;
  assign wr      = take && link.req_write;
  assign ov_prod = 28'(strap_s2_q[15:0]) * 28'(cfg_cmd_pkg::OV_NUM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_q  <= cfg_cmd_pkg::SLEW_RESET;
      droop_q <= cfg_cmd_pkg::LOAD_LINE_RESET;
      freq_q  <= '0;
      pos_q   <= '0;
      ov_q    <= '0;
    end else if (strap_load) begin
      freq_q <= strap_s2_q[38:23];
      pos_q  <= {12'h000, strap_s2_q[19:16]};
      ov_q   <= ov_prod[cfg_cmd_pkg::OV_SHIFT +: 16];
    end else if (wr) begin
      unique case (link.req_code)
        cfg_cmd_pkg::CMD_MARGIN_SLEW:  slew_q  <= link.req_wdata;
        cfg_cmd_pkg::CMD_LOAD_LINE:    droop_q <= link.req_wdata;
        cfg_cmd_pkg::CMD_SW_FREQ:      freq_q  <= link.req_wdata;
        cfg_cmd_pkg::CMD_PHASE_POS:    pos_q   <= {12'h000, link.req_wdata[cfg_cmd_pkg::POS_MSB:0]};
        cfg_cmd_pkg::CMD_OV_THRESHOLD: ov_q    <= link.req_wdata;
        default:                       ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      unsup_q <= 1'b0;
      rdata_q <= '0;
      on_q    <= 1'b0;
    end else begin
      ack_q <= take;
      on_q  <= output_enable;
      if (take) begin
        unsup_q <= 1'b0;
        unique case (link.req_code)
          cfg_cmd_pkg::CMD_MARGIN_SLEW:  rdata_q <= slew_q;
          cfg_cmd_pkg::CMD_LOAD_LINE:    rdata_q <= droop_q;
          cfg_cmd_pkg::CMD_SW_FREQ:      rdata_q <= freq_q;
          cfg_cmd_pkg::CMD_PHASE_POS:    rdata_q <= pos_q;
          cfg_cmd_pkg::CMD_OV_THRESHOLD: rdata_q <= ov_q;
          default: begin
            rdata_q <= '0;
            unsup_q <= 1'b1;
          end
        endcase
      end
    end
  end
  assign link.ack             = ack_q;
  assign link.ack_unsupported = unsup_q;
  assign link.ack_rdata       = rdata_q;
  assign link.output_on       = on_q;

  // ****************************************
  // margin slew
  // ****************************************
  // exponent/mantissa rate to step
  function automatic logic [23:0] slew_step(input logic [15:0] w);
    logic signed [4:0]  n;
    logic signed [10:0] y;
    logic        [39:0] p;
    int                 sh;
    n  = w[cfg_cmd_pkg::EXP_MSB:cfg_cmd_pkg::EXP_LSB];
    y  = w[cfg_cmd_pkg::MANT_MSB:0];
    p  = 40'(y[9:0]) * 40'(cfg_cmd_pkg::SLEW_SCALE);
    sh = cfg_cmd_pkg::SLEW_SHIFT - int'(n);
    if (y <= 0) begin
      p = '0;
    end else if (sh >= 0) begin
      p = p >> sh;
    end else begin
      p = p << (-sh);
    end
    if (p > 40'h0000FFFFFF) begin
      p = 40'h0000FFFFFF;
    end
    if (p == '0 && y > 0) begin
      p = 40'h1;
    end
    return p[23:0];
  endfunction : slew_step

  logic [23:0] target_q;
  logic [6:0]  tick_cnt_q;
  logic        tick;
  logic [23:0] goal;
  logic [23:0] step;
  logic        jump;

  assign tick = (tick_cnt_q == 7'(cfg_cmd_pkg::TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? 7'h00 : tick_cnt_q + 7'h01;
    end
  end

  always_comb begin
    unique case (margin_select)
      2'h1:    goal = {vout_margin_low, 8'h00};
      2'h2:    goal = {vout_margin_high, 8'h00};
      default: goal = {vout_nominal, 8'h00};
    endcase
  end
  assign step = slew_step(slew_q);
  // fastest code, bad rate, output disabled or output ramping jumps
  assign jump = (slew_q == cfg_cmd_pkg::SLEW_FASTEST) || (step == '0) || !output_enable || output_ramping;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_q <= '0;
    end else if (jump) begin
      target_q <= goal;
    end else if (tick) begin
      if (goal > target_q) begin
        target_q <= (goal - target_q > step) ? target_q + step : goal;
      end else if (goal < target_q) begin
        target_q <= (target_q - goal > step) ? target_q - step : goal;
      end
    end
  end

  // ****************************************
  // droop
  // ****************************************
  logic signed [4:0]  dr_n;
  logic signed [10:0] dr_y;
  logic signed [43:0] dr_p;
  logic signed [43:0] dr_off;
  logic signed [43:0] sp;
  logic        [15:0] sp_q;
  int                 dr_sh;

  always_comb begin
    dr_n  = droop_q[cfg_cmd_pkg::EXP_MSB:cfg_cmd_pkg::EXP_LSB];
    dr_y  = droop_q[cfg_cmd_pkg::MANT_MSB:0];
    dr_p  = 44'(dr_y) * 44'(signed'(iout_ma)) * 44'(signed'({1'b0, cfg_cmd_pkg::DROOP_SCALE}));
    dr_sh = cfg_cmd_pkg::DROOP_SHIFT - int'(dr_n);
    dr_off = dr_p >>> dr_sh;
    sp = 44'(signed'({1'b0, target_q[23:8]})) - dr_off;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= '0;
    end else if (sp < 0) begin
      sp_q <= '0;
    end else if (sp > 44'sh0FFFF) begin
      sp_q <= 16'hFFFF;
    end else begin
      sp_q <= sp[15:0];
    end
  end
  assign vout_setpoint = sp_q;

  // ****************************************
  // switching frequency divisor
  // ****************************************
  logic signed [4:0]  fq_n;
  logic signed [10:0] fq_y;
  logic        [31:0] fq_wide;
  logic        [15:0] fq_khz;
  logic        [6:0]  div_q;
  logic        [6:0]  srch_q;
  logic               searching_q;
  logic        [22:0] div_prod;

  always_comb begin
    fq_n = freq_q[cfg_cmd_pkg::EXP_MSB:cfg_cmd_pkg::EXP_LSB];
    fq_y = freq_q[cfg_cmd_pkg::MANT_MSB:0];
    if (fq_y <= 0) begin
      fq_wide = '0;
    end else if (fq_n >= 0) begin
      fq_wide = 32'(fq_y[9:0]) << fq_n;
    end else begin
      fq_wide = 32'(fq_y[9:0]) >> (-fq_n);
    end
    fq_khz = (fq_wide > 32'h0000FFFF) ? 16'hFFFF : fq_wide[15:0];
  end
  assign div_prod = 23'(srch_q) * 23'(fq_khz);

  // smallest n in range with fref/n <= f
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srch_q      <= cfg_cmd_pkg::DIV_MIN;
      searching_q <= 1'b0;
      div_q       <= cfg_cmd_pkg::DIV_MAX;
    end else if (strap_load || (wr && link.req_code == cfg_cmd_pkg::CMD_SW_FREQ)) begin
      srch_q      <= cfg_cmd_pkg::DIV_MIN;
      searching_q <= 1'b1;
    end else if (searching_q) begin
      if (div_prod >= 23'(cfg_cmd_pkg::FREF_KHZ) || srch_q == cfg_cmd_pkg::DIV_MAX) begin
        div_q       <= srch_q;
        searching_q <= 1'b0;
      end else begin
        srch_q <= srch_q + 7'h01;
      end
    end
  end
  assign freq_divisor = div_q;

  // ****************************************
  // interleave position
  // ****************************************
  logic [4:0]  pos_eff_q;
  logic [6:0]  delay_q;
  logic [3:0]  pos_src;
  logic [4:0]  pos_eff;
  logic [11:0] delay_prod;

  assign pos_src    = share_group ? auto_position : pos_q[cfg_cmd_pkg::POS_MSB:0];
  assign pos_eff    = (pos_src == 4'h0) ? cfg_cmd_pkg::POS_ZERO_AS : {1'b0, pos_src};
  assign delay_prod = 12'(pos_eff) * 12'(div_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_eff_q <= cfg_cmd_pkg::POS_ZERO_AS;
      delay_q   <= '0;
    end else begin
      pos_eff_q <= pos_eff;
      delay_q   <= delay_prod[10:4];
    end
  end
  assign phase_position_eff = pos_eff_q;
  assign phase_delay_ticks  = delay_q;

  assign ov_threshold = ov_q;
endmodule : cfg_cmd_regs

/* File: cfg_cmd_pkg.sv */
// Purpose: shared constants for the output configuration command link
// Assumes: 125 MHz pclk, 16-bit command words
// Notes:   command codes, reset values, scaling and host register map
package cfg_cmd_pkg;
  // ****************************************
  // command codes and widths
  // ****************************************
  localparam logic [7:0]  CMD_MARGIN_SLEW   = 8'h27;
  localparam logic [7:0]  CMD_LOAD_LINE     = 8'h28;
  localparam logic [7:0]  CMD_SW_FREQ       = 8'h33;
  localparam logic [7:0]  CMD_PHASE_POS     = 8'h37;
  localparam logic [7:0]  CMD_OV_THRESHOLD  = 8'h40;
  localparam int          CODE_W            = 8;
  localparam int          WORD_W            = 16;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [15:0] SLEW_RESET        = 16'hBA00;
  localparam logic [15:0] LOAD_LINE_RESET   = 16'h0000;
  localparam logic [15:0] SLEW_FASTEST      = 16'h7FFF;
  localparam int          EXP_MSB           = 15;
  localparam int          EXP_LSB           = 11;
  localparam int          MANT_MSB          = 10;
  localparam int          POS_MSB           = 3;
  localparam logic [4:0]  POS_ZERO_AS       = 5'h10;
  localparam logic [1:0]  STRAP_LOAD_CNT    = 2'h2;

  // ****************************************
  // scaling
  // ****************************************
  // 8.192 lsb/us per V/ms, as 8389/1024, with 8 fraction bits
  localparam logic [13:0] SLEW_SCALE        = 14'h20C5;
  localparam int          SLEW_SHIFT        = 2;
  // mV/A * mA -> 2^-13 V lsb, as 8590/2^20
  localparam logic [14:0] DROOP_SCALE       = 15'h218E;
  localparam int          DROOP_SHIFT       = 20;
  localparam logic [15:0] FREF_KHZ          = 16'h3E80;
  localparam logic [6:0]  DIV_MIN           = 7'h0C;
  localparam logic [6:0]  DIV_MAX           = 7'h50;
  // 1.15 as 2355/2048
  localparam logic [11:0] OV_NUM            = 12'h933;
  localparam int          OV_SHIFT          = 11;
  localparam int          CLK_MHZ           = 125;
  localparam int          TICK_NS           = 1000;
  localparam int          TICK_CYC          = (TICK_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // host register map (apb byte addresses)
  // ****************************************
  localparam logic [7:0]  HOST_CMD          = 8'h00;
  localparam logic [7:0]  HOST_WDATA        = 8'h04;
  localparam logic [7:0]  HOST_STATUS       = 8'h08;
  localparam logic [7:0]  HOST_RDATA        = 8'h0C;
  localparam int          CMD_WRITE_BIT     = 8;
  localparam int          ST_BUSY           = 0;
  localparam int          ST_DONE           = 1;
  localparam int          ST_UNSUPPORTED    = 2;
  localparam int          ST_REFUSED        = 3;
  localparam int          ST_OUTPUT_ON      = 4;
endpackage : cfg_cmd_pkg

/* File: cfg_cmd_if.sv */
// Purpose: command link between host controller and configuration registers
// Assumes: one clock, request held until acknowledged
// Notes:   ack is a one-cycle pulse; write takes effect at the ack edge
`timescale 1ns/100ps
interface cfg_cmd_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        req;
  logic        req_write;
  logic [7:0]  req_code;
  logic [15:0] req_wdata;
  logic        ack;
  logic        ack_unsupported;
  logic [15:0] ack_rdata;
  logic        output_on;

  modport device (
    input  req,
    input  req_write,
    input  req_code,
    input  req_wdata,
    output ack,
    output ack_unsupported,
    output ack_rdata,
    output output_on
  );

  modport host (
    output req,
    output req_write,
    output req_code,
    output req_wdata,
    input  ack,
    input  ack_unsupported,
    input  ack_rdata,
    input  output_on
  );
endinterface : cfg_cmd_if

/* File: cfg_cmd_host.sv */
// Purpose: host end issuing configuration commands ordered over apb
// Assumes: software computes droop and frequency words
// Notes:   apb answers with no wait states; one command at a time
`timescale 1ns/100ps
module cfg_cmd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  cfg_cmd_if.host          link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  // ****************************************
  // apb slave
  // ****************************************
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        setup;
  logic        wr_cmd;
  logic        mapped;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        done_q;
  logic        unsup_q;
  logic        refused_q;
  logic        req_q;
  logic        req_write_q;
  logic [7:0]  req_code_q;
  logic [31:0] status;
  logic        refuse;

  assign setup  = psel && !penable;
  assign mapped = (paddr == cfg_cmd_pkg::HOST_CMD) || (paddr == cfg_cmd_pkg::HOST_WDATA) ||
                  (paddr == cfg_cmd_pkg::HOST_STATUS) || (paddr == cfg_cmd_pkg::HOST_RDATA);
  assign wr_cmd = psel && penable && pready_q && pwrite && (paddr == cfg_cmd_pkg::HOST_CMD) && !req_q;
  assign status = {27'h0, link.output_on, refused_q, unsup_q, done_q, req_q};
  assign refuse = pwdata[cfg_cmd_pkg::CMD_WRITE_BIT] && (pwdata[7:0] == cfg_cmd_pkg::CMD_SW_FREQ) && link.output_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) begin
        unique case (paddr)
          cfg_cmd_pkg::HOST_CMD:    prdata_q <= {23'h0, req_write_q, req_code_q};
          cfg_cmd_pkg::HOST_WDATA:  prdata_q <= {16'h0, wdata_q};
          cfg_cmd_pkg::HOST_STATUS: prdata_q <= status;
          cfg_cmd_pkg::HOST_RDATA:  prdata_q <= {16'h0, rdata_q};
          default:                  prdata_q <= '0;
        endcase
      end
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_q <= '0;
    end else if (psel && penable && pready_q && pwrite && paddr == cfg_cmd_pkg::HOST_WDATA) begin
      wdata_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // command link
  // ****************************************
  // request held until the one-cycle ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q       <= 1'b0;
      req_write_q <= 1'b0;
      req_code_q  <= '0;
      done_q      <= 1'b0;
      unsup_q     <= 1'b0;
      refused_q   <= 1'b0;
      rdata_q     <= '0;
    end else if (wr_cmd) begin
      req_code_q  <= pwdata[7:0];
      req_write_q <= pwdata[cfg_cmd_pkg::CMD_WRITE_BIT];
      req_q       <= !refuse;
      done_q      <= refuse;
      refused_q   <= refuse;
      unsup_q     <= 1'b0;
    end else if (req_q && link.ack) begin
      req_q   <= 1'b0;
      done_q  <= 1'b1;
      unsup_q <= link.ack_unsupported;
      if (!req_write_q) begin
        rdata_q <= link.ack_rdata;
      end
    end
  end
  assign link.req       = req_q;
  assign link.req_write = req_write_q;
  assign link.req_code  = req_code_q;
  assign link.req_wdata = wdata_q;
endmodule : cfg_cmd_host

/* File: cfg_cmd_properties.sv */
// Purpose: link checks for the configuration command interface
// Assumes: one clock; ack one cycle after the take edge
// Notes:   shadows follow written words so reads can be judged
`timescale 1ns/100ps
module cfg_cmd_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        req_write,
  input wire logic [7:0]  req_code,
  input wire logic [15:0] req_wdata,
  input wire logic        ack,
  input wire logic        ack_unsupported,
  input wire logic [15:0] ack_rdata,
  input wire logic        output_on
);
  logic [15:0] slew_q;
  logic [15:0] droop_q;
  logic [15:0] ov_q;
  logic        ov_set_q;
  logic        rd;
  logic        known;
  assign rd = ack && !req_write;
  assign known = req_code inside {cfg_cmd_pkg::CMD_MARGIN_SLEW, cfg_cmd_pkg::CMD_LOAD_LINE,
    cfg_cmd_pkg::CMD_SW_FREQ, cfg_cmd_pkg::CMD_PHASE_POS, cfg_cmd_pkg::CMD_OV_THRESHOLD};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // shadows of written words
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_q   <= cfg_cmd_pkg::SLEW_RESET;
      droop_q  <= cfg_cmd_pkg::LOAD_LINE_RESET;
      ov_q     <= 16'h0000;
      ov_set_q <= 1'b0;
    end else if (ack && req_write) begin
      if (req_code == cfg_cmd_pkg::CMD_MARGIN_SLEW) slew_q <= req_wdata;
      if (req_code == cfg_cmd_pkg::CMD_LOAD_LINE) droop_q <= req_wdata;
      if (req_code == cfg_cmd_pkg::CMD_OV_THRESHOLD) begin
        ov_q     <= req_wdata;
        ov_set_q <= 1'b1;
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> req && $past(req)) else $error("ack without request");
  ack_bound_a: assert property ($rose(req) |-> ##[1:8] ack) else $error("request not answered");
  req_held_a: assert property (req && !ack |=> req && $stable(req_code) && $stable(req_wdata))
    else $error("request dropped early");
  slew_read_a: assert property (rd && req_code == cfg_cmd_pkg::CMD_MARGIN_SLEW |-> ack_rdata == slew_q)
    else $error("rate word wrong");
  droop_read_a: assert property (rd && req_code == cfg_cmd_pkg::CMD_LOAD_LINE |-> ack_rdata == droop_q)
    else $error("droop word wrong");
  ov_read_a: assert property (rd && ov_set_q && req_code == cfg_cmd_pkg::CMD_OV_THRESHOLD |-> ack_rdata == ov_q)
    else $error("ov word wrong");
  pos_upper_a: assert property (rd && req_code == cfg_cmd_pkg::CMD_PHASE_POS |-> ack_rdata[15:4] == 12'h000)
    else $error("position upper bits set");
  unknown_code_a: assert property (ack && !known |-> ack_unsupported && ack_rdata == 16'h0000)
    else $error("unknown code not flagged");
  freq_off_a: assert property ($rose(req) && req_write && req_code == cfg_cmd_pkg::CMD_SW_FREQ |-> !$past(output_on))
    else $error("frequency write while on");
  cover property (ack && req_write && req_code == cfg_cmd_pkg::CMD_SW_FREQ);
  cover property (ack && ack_unsupported);
  cover property (rd && req_code == cfg_cmd_pkg::CMD_PHASE_POS);
endmodule : cfg_cmd_properties

/* File: output_config_command_regs_tb_top.sv */
// Purpose: self-checking bench for host and device ends over apb
// Assumes: straps static; output off unless a scenario turns it on
// Notes:   expected words come from a small model of written values
`timescale 1ns/100ps
module output_config_command_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, st;
  logic [15:0] strap_freq_word, strap_vout_word, vout_nominal, vout_margin_high, vout_margin_low;
  logic [15:0] iout_ma, vout_setpoint, ov_threshold, rd, w;
  logic [6:0] strap_address, freq_divisor, phase_delay_ticks;
  logic [4:0] phase_position_eff;
  logic [3:0] auto_position;
  logic [1:0] margin_select;
  logic output_enable, output_ramping, share_group;
  int miscompares, samples_checked, seed, pos;
  int model[int];
  logic [7:0] codes[5] = '{8'h27, 8'h28, 8'h40, 8'h37, 8'h33};
  cfg_cmd_if u_cfg_cmd_if (.pclk(pclk), .presetn(presetn));
  cfg_cmd_regs u_cfg_cmd_regs (.pclk(pclk), .presetn(presetn), .link(u_cfg_cmd_if.device),
    .strap_freq_word(strap_freq_word), .strap_address(strap_address), .strap_vout_word(strap_vout_word),
    .output_enable(output_enable), .output_ramping(output_ramping), .margin_select(margin_select),
    .vout_nominal(vout_nominal), .vout_margin_high(vout_margin_high), .vout_margin_low(vout_margin_low),
    .iout_ma(iout_ma), .share_group(share_group), .auto_position(auto_position),
    .vout_setpoint(vout_setpoint), .freq_divisor(freq_divisor), .phase_position_eff(phase_position_eff),
    .phase_delay_ticks(phase_delay_ticks), .ov_threshold(ov_threshold));
  cfg_cmd_host u_cfg_cmd_host (.pclk(pclk), .presetn(presetn), .link(u_cfg_cmd_if.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cfg_cmd_properties u_cfg_cmd_properties (.pclk(pclk), .presetn(presetn), .req(u_cfg_cmd_if.req),
    .req_write(u_cfg_cmd_if.req_write), .req_code(u_cfg_cmd_if.req_code), .req_wdata(u_cfg_cmd_if.req_wdata),
    .ack(u_cfg_cmd_if.ack), .ack_unsupported(u_cfg_cmd_if.ack_unsupported), .ack_rdata(u_cfg_cmd_if.ack_rdata),
    .output_on(u_cfg_cmd_if.output_on));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin miscompares++; test_done(); end
  endtask : apb
  // status polled until done, then the read word fetched
  task cmd(input logic wr, input logic [7:0] c, input logic [15:0] d);
    int n;
    apb(1'b1, cfg_cmd_pkg::HOST_WDATA, {16'h0000, d});
    apb(1'b1, cfg_cmd_pkg::HOST_CMD, {23'h0, wr, c});
    n = 0;
    do begin apb(1'b0, cfg_cmd_pkg::HOST_STATUS, 32'h0); n++; end while (r[1] !== 1'b1 && n < 20);
    st = r;
    apb(1'b0, cfg_cmd_pkg::HOST_RDATA, 32'h0);
    rd = r[15:0];
    if (n >= 20) begin miscompares++; test_done(); end
  endtask : cmd
  function automatic int div_of(int f);
    for (int n = 12; n <= 80; n++) if (n * f >= 16000) return n;
    return 80;
  endfunction : div_of
  initial begin
    seed = 32'hc9fd4d36;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    strap_freq_word = 16'h01F4; strap_address = 7'h20;
    strap_vout_word = 16'h2000 | (16'($random(seed)) & 16'h0FFF);
    {output_enable, output_ramping, share_group, margin_select, auto_position} = '0;
    vout_nominal = 16'h4000; vout_margin_high = 16'h5000; vout_margin_low = 16'h3000; iout_ma = 16'h0000;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (100) @(posedge pclk);
    check("divisor", freq_divisor, div_of(500));
    check("position", phase_position_eff, 32'h10);
    check("ov", ov_threshold, (int'(strap_vout_word) * 2355) >> 11);
    cmd(1'b0, 8'h27, 16'h0); check("slew", rd, 16'hBA00);
    cmd(1'b0, 8'h28, 16'h0); check("droop", rd, 16'h0000);
    cmd(1'b0, 8'h33, 16'h0); check("freq", rd, 16'h01F4);
    cmd(1'b0, 8'h37, 16'h0); check("pos", rd, 16'h0000);
    foreach (codes[i]) begin
      w = 16'($random(seed));
      if (codes[i] == 8'h33) w = 16'(200 + ($unsigned($random(seed)) % 824));
      model[codes[i]] = (codes[i] == 8'h37) ? (w & 16'h000F) : w;
      cmd(1'b1, codes[i], w); cmd(1'b0, codes[i], 16'h0);
      check("readback", rd, model[codes[i]]);
    end
    // divisor search after a frequency write may need 69 clocks
    repeat (80) @(posedge pclk);
    check("ov out", ov_threshold, model[8'h40]);
    check("new divisor", freq_divisor, div_of(model[8'h33]));
    pos = (model[8'h37] == 0) ? 16 : model[8'h37];
    check("delay", phase_delay_ticks, (pos * div_of(model[8'h33])) >> 4);
    cmd(1'b1, 8'h37, 16'hFFF0);
    check("delay zero", phase_delay_ticks, div_of(model[8'h33]));
    share_group <= 1'b1; auto_position <= 4'h3;
    repeat (5) @(posedge pclk);
    check("auto pos", phase_position_eff, 32'h3);
    share_group <= 1'b0;
    cmd(1'b1, 8'h28, 16'h4801); iout_ma <= 16'h0400;
    repeat (10) @(posedge pclk);
    check("droop", vout_setpoint, 16'h2F39);
    iout_ma <= 16'hFC00;
    repeat (10) @(posedge pclk);
    check("sink", vout_setpoint, 16'h50C7);
    iout_ma <= 16'h0000; output_enable <= 1'b1;
    cmd(1'b1, 8'h33, 16'h0190); check("refused", st[3], 1);
    cmd(1'b0, 8'h33, 16'h0); check("freq kept", rd, model[8'h33]);
    cmd(1'b1, 8'h27, 16'hBA00); margin_select <= 2'h2;
    repeat (20) @(posedge pclk);
    check("slewing", vout_setpoint < 16'h5000, 1);
    repeat (280) @(posedge pclk);
    check("slew rate", vout_setpoint > 16'h4000 && vout_setpoint < 16'h4020, 1);
    cmd(1'b1, 8'h27, cfg_cmd_pkg::SLEW_FASTEST); margin_select <= 2'h1;
    repeat (10) @(posedge pclk);
    check("fastest", vout_setpoint, 16'h3000);
    cmd(1'b1, 8'h27, 16'hBA00); output_ramping <= 1'b1; margin_select <= 2'h2;
    repeat (10) @(posedge pclk);
    check("ramp jump", vout_setpoint, 16'h5000);
    apb(1'b0, 8'h10, 32'h0); check("slverr", err, 1);
    cmd(1'b0, 8'h55, 16'h0); check("unsupported", {st[2], rd}, {1'b1, 16'h0000});
    test_done();
  end
endmodule : output_config_command_regs_tb_top
